/* src/hwcu_top.sv */
// Host watchdog command unit with AXI4-Lite register slave
`timescale 1ns/10ps
`include "hwcu_cfg.svh"
module hwcu_top import hwcu_pkg::*; #(
    parameter int TICK_CYCLES = `HWCU_UNIT_CYC,
    parameter int BUF_LEN = 12
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Received characters
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_err,
    // Reply characters
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // Nonvolatile status image
    input wire logic nv_flag_in,
    input wire logic nv_en_in,
    input wire logic [7:0] nv_period_in,
    output logic nv_flag,
    output logic nv_en,
    output logic [7:0] nv_period,
    // Output channel defaults
    output logic [7:0] do_power_on_val,
    output logic [7:0] do_safe_val
);
    // Refuse sizes the buffer index and divider cannot serve
    if (TICK_CYCLES < 2 || BUF_LEN < 9 || BUF_LEN > 15) begin : g_bad_cfg
        $error("hwcu_top: unsupported parameter value");
    end

    // ----------------------------------------------------------
    // Registers and watchdog state
    // ----------------------------------------------------------
    logic [7:0] my_addr_q;
    logic cs_en_q;
    logic [7:0] pwr_mask_q, safe_mask_q, alarm_q;
    logic wdt_flag_q, wdt_en_q, loaded_q;
    logic [7:0] wdt_period_q, wdt_cnt_q;
    logic [31:0] tick_cnt_q;
    logic tick;
    hwcu_state_e state_q;

    // ----------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------
    logic aw_got_q, w_got_q, wr_do;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready = !w_got_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_do = aw_got_q && w_got_q && !s_axi_bvalid;

    // Address and data taken in either order
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0;
            ws_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                aw_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                w_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (wr_do) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_q == `HWCU_OFS_CTRL ||
                    aw_q == `HWCU_OFS_MASKS ||
                    aw_q == `HWCU_OFS_STATUS) ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            my_addr_q <= `HWCU_RST_ADDR;
            cs_en_q <= 1'b0;
            {alarm_q, safe_mask_q, pwr_mask_q} <= `HWCU_RST_MASKS;
        end else if (wr_do && aw_q == `HWCU_OFS_CTRL) begin
            if (ws_q[0]) my_addr_q <= w_q[7:0];
            if (ws_q[1]) cs_en_q <= w_q[`HWCU_BIT_CSEN];
        end else if (wr_do && aw_q == `HWCU_OFS_MASKS) begin
            if (ws_q[0]) pwr_mask_q <= w_q[7:0];
            if (ws_q[1]) safe_mask_q <= w_q[15:8];
            if (ws_q[2]) alarm_q <= w_q[23:16];
        end
    end

    // Read port
    logic [31:0] status_word;
    always_comb begin
        status_word = {8'h00, wdt_cnt_q, wdt_period_q, 8'h00};
        status_word[`HWCU_BIT_FLAG] = wdt_flag_q;
        status_word[`HWCU_BIT_EN] = wdt_en_q;
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `HWCU_OFS_CTRL: s_axi_rdata <= {23'h0, cs_en_q, my_addr_q};
                `HWCU_OFS_STATUS: s_axi_rdata <= status_word;
                `HWCU_OFS_MASKS:
                    s_axi_rdata <= {8'h00, alarm_q, safe_mask_q, pwr_mask_q};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------
    // Frame collection
    // ----------------------------------------------------------
    hwcu_char_t buf_q [0:BUF_LEN-1];
    logic [3:0] len_q;
    logic drop_q, go;
    assign go = rx_valid && rx_data == `HWCU_CH_CR && !rx_err &&
        !drop_q && state_q == HWCU_ST_COLLECT;

    // Errors, overflow and busy periods spoil the frame
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            len_q <= 4'h0;
            drop_q <= 1'b0;
        end else if (rx_valid) begin
            if (rx_data == `HWCU_CH_CR && !rx_err) begin
                len_q <= 4'h0;
                drop_q <= 1'b0;
            end else if (rx_err || len_q == 4'(BUF_LEN) ||
                         state_q != HWCU_ST_COLLECT) begin
                drop_q <= 1'b1;
            end else begin
                len_q <= len_q + 4'h1;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (rx_valid && len_q < 4'(BUF_LEN)) buf_q[len_q] <= rx_data;
    end

    // ----------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------
    logic [3:0] body;
    logic [7:0] sum, cs_rx;
    logic [4:0] ah, al, ch, cl, th, tl;
    logic cs_ok, alive, match, is_rd, is_clr, is_per, is_set, is_def;
    logic ok, set_en;
    always_comb begin
        body = cs_en_q ? len_q - 4'h2 : len_q;
        sum = 8'h00;
        for (int i = 0; i < BUF_LEN; i++)
            if (i < int'(body)) sum = sum + buf_q[i];
        ch = hwcu_hex_val(buf_q[body]);
        cl = hwcu_hex_val(buf_q[4'(body + 4'h1)]);
        cs_rx = {ch[3:0], cl[3:0]};
        cs_ok = !cs_en_q || (len_q >= 4'h2 && ch[4] && cl[4] &&
            cs_rx == sum);
        ah = hwcu_hex_val(buf_q[1]);
        al = hwcu_hex_val(buf_q[2]);
        th = hwcu_hex_val(buf_q[5]);
        tl = hwcu_hex_val(buf_q[6]);
        alive = body == 4'h3 && buf_q[0] == `HWCU_CH_LEAD &&
            buf_q[1] == `HWCU_CH_STAR && buf_q[2] == `HWCU_CH_STAR;
        // Foreign or unparsable address stays silent
        match = cs_ok && !alive && body >= 4'h4 &&
            buf_q[0] == `HWCU_CH_LEAD && ah[4] && al[4] &&
            {ah[3:0], al[3:0]} == my_addr_q;
        is_rd = body == 4'h4 && buf_q[3] == `HWCU_CH_ZERO;
        is_clr = body == 4'h4 && buf_q[3] == `HWCU_CH_ONE;
        is_per = body == 4'h4 && buf_q[3] == `HWCU_CH_TWO;
        is_def = body == 4'h4 && buf_q[3] == `HWCU_CH_FOUR;
        set_en = buf_q[4] == `HWCU_CH_ONE;
        is_set = body == 4'h7 && buf_q[3] == `HWCU_CH_THREE &&
            (set_en || buf_q[4] == `HWCU_CH_ZERO) && th[4] && tl[4] &&
            {th[3:0], tl[3:0]} != 8'h00;
        ok = is_rd || is_clr || is_per || is_set || is_def;
    end

    // ----------------------------------------------------------
    // Reply assembly
    // ----------------------------------------------------------
    hwcu_char_t r [0:9];
    logic [3:0] n;
    logic [7:0] rsum;
    always_comb begin
        for (int i = 0; i < 10; i++) r[i] = `HWCU_CH_CR;
        r[0] = ok ? `HWCU_CH_ACK : `HWCU_CH_NAK;
        r[1] = hwcu_hex_char(my_addr_q[7:4]);
        r[2] = hwcu_hex_char(my_addr_q[3:0]);
        n = 4'h3;
        if (ok && is_rd) begin
            r[3] = hwcu_hex_char({wdt_en_q, 3'h0});
            r[4] = hwcu_hex_char({1'b0, wdt_flag_q, 2'h0});
            n = 4'h5;
        end else if (ok && is_per) begin
            r[3] = wdt_en_q ? `HWCU_CH_ONE : `HWCU_CH_ZERO;
            r[4] = hwcu_hex_char(wdt_period_q[7:4]);
            r[5] = hwcu_hex_char(wdt_period_q[3:0]);
            n = 4'h6;
        end else if (ok && is_def) begin
            r[3] = hwcu_hex_char(pwr_mask_q[7:4]);
            r[4] = hwcu_hex_char(pwr_mask_q[3:0]);
            r[5] = hwcu_hex_char(safe_mask_q[7:4]);
            r[6] = hwcu_hex_char(safe_mask_q[3:0]);
            n = 4'h7;
        end
        rsum = 8'h00;
        for (int i = 0; i < 7; i++)
            if (i < int'(n)) rsum = rsum + r[i];
        if (cs_en_q) begin
            r[n] = hwcu_hex_char(rsum[7:4]);
            r[4'(n + 4'h1)] = hwcu_hex_char(rsum[3:0]);
            n = n + 4'h2;
        end
        r[n] = `HWCU_CH_CR;
        n = n + 4'h1;
    end

    // ----------------------------------------------------------
    // Reply sender
    // ----------------------------------------------------------
    hwcu_char_t txb_q [0:9];
    logic [3:0] tx_len_q, tx_idx_q;
    logic last;
    assign tx_valid = state_q == HWCU_ST_REPLY;
    assign last = tx_idx_q + 4'h1 == tx_len_q;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= HWCU_ST_COLLECT;
            tx_idx_q <= 4'h0;
            tx_len_q <= 4'h0;
            tx_data <= 8'h00;
        end else begin
            case (state_q)
                HWCU_ST_COLLECT: begin
                    if (go && match) begin
                        state_q <= HWCU_ST_REPLY;
                        tx_idx_q <= 4'h0;
                        tx_len_q <= n;
                        tx_data <= r[0];
                    end
                end
                HWCU_ST_REPLY: begin
                    if (tx_ready && last) begin
                        state_q <= HWCU_ST_COLLECT;
                    end else if (tx_ready) begin
                        tx_idx_q <= tx_idx_q + 4'h1;
                        tx_data <= txb_q[4'(tx_idx_q + 4'h1)];
                    end
                end
                default: state_q <= HWCU_ST_COLLECT;
            endcase
        end
    end
    always_ff @(posedge core_clk) begin
        if (go && match) txb_q <= r;
    end

    // ----------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------
    logic restart, timeout_ev, do_set, do_clr;
    assign do_set = go && match && is_set;
    assign do_clr = go && match && is_clr;
    assign restart = (go && alive && cs_ok) || do_set;
    assign tick = tick_cnt_q == 32'(TICK_CYCLES - 1);
    assign timeout_ev = wdt_en_q && tick && !restart &&
        wdt_cnt_q + 8'h01 >= wdt_period_q;

    // Tenth-of-a-second divider
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) tick_cnt_q <= 32'h0;
        else if (tick || restart) tick_cnt_q <= 32'h0;
        else tick_cnt_q <= tick_cnt_q + 32'h1;
    end

    // Period count, enable, flag; image loaded once after reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            loaded_q <= 1'b0;
            wdt_flag_q <= 1'b0;
            wdt_en_q <= 1'b0;
            wdt_period_q <= 8'h00;
            wdt_cnt_q <= 8'h00;
        end else if (!loaded_q) begin
            loaded_q <= 1'b1;
            wdt_flag_q <= nv_flag_in;
            wdt_en_q <= nv_en_in;
            wdt_period_q <= nv_period_in;
        end else begin
            if (timeout_ev) wdt_flag_q <= 1'b1;
            else if (do_clr) wdt_flag_q <= 1'b0;
            if (timeout_ev) wdt_en_q <= 1'b0;
            else if (do_set) wdt_en_q <= set_en;
            if (do_set) wdt_period_q <= {th[3:0], tl[3:0]};
            if (restart || timeout_ev || !wdt_en_q) wdt_cnt_q <= 8'h00;
            else if (tick) wdt_cnt_q <= wdt_cnt_q + 8'h01;
        end
    end
    assign nv_flag = wdt_flag_q;
    assign nv_en = wdt_en_q;
    assign nv_period = wdt_period_q;

    // Alarm-assigned channels take no default values
    assign do_power_on_val = pwr_mask_q & ~alarm_q;
    assign do_safe_val = safe_mask_q & ~alarm_q;

    // ----------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_timeout_sets_flag: assert property (
        loaded_q && timeout_ev |=> wdt_flag_q) else $error("flag not set");
    a_timeout_disables: assert property (
        loaded_q && timeout_ev |=> !wdt_en_q) else $error("still enabled");
    a_flag_holds: assert property (
        loaded_q && wdt_flag_q && !do_clr |=> wdt_flag_q)
        else $error("flag lost");
    a_clear_flag: assert property (
        do_clr && !timeout_ev |=> !wdt_flag_q && tx_data == `HWCU_CH_ACK)
        else $error("clear failed");
    a_alive_silent: assert property (
        go && alive |=> state_q == HWCU_ST_COLLECT)
        else $error("answered alive");
    a_foreign_silent: assert property (
        go && !match |=> !tx_valid) else $error("spoke out of turn");
    a_set_stores: assert property (
        do_set && !timeout_ev |=> wdt_en_q == $past(set_en) &&
        wdt_period_q == $past({th[3:0], tl[3:0]}))
        else $error("set not stored");
    a_reply_lead: assert property (
        $rose(tx_valid) |-> tx_data == `HWCU_CH_ACK ||
        tx_data == `HWCU_CH_NAK) else $error("bad lead char");
    a_reply_ends_cr: assert property (
        tx_valid && tx_ready && last |-> tx_data == `HWCU_CH_CR)
        else $error("reply not ended by CR");
    a_alarm_masked: assert property (
        ((do_power_on_val | do_safe_val) & alarm_q) == 8'h00)
        else $error("alarm channel defaulted");
    c_timeout: cover property (timeout_ev);
    c_set_ok: cover property (do_set ##[1:20] !tx_valid);
    c_nak: cover property (go && match && !ok);
endmodule

/* src/hwcu_cfg.svh */
// Constants of the host watchdog command unit
`ifndef HWCU_CFG_SVH
`define HWCU_CFG_SVH
// Register byte offsets
`define HWCU_OFS_CTRL 8'h00
`define HWCU_OFS_STATUS 8'h04
`define HWCU_OFS_MASKS 8'h08
// Field positions
`define HWCU_BIT_FLAG 2
`define HWCU_BIT_EN 7
`define HWCU_BIT_CSEN 8
// Reset values
`define HWCU_RST_ADDR 8'h01
`define HWCU_RST_MASKS 24'h000000
// Timing: one period unit is 0.1 s
`define HWCU_UNIT_NS 100000000
`define HWCU_CLK_NS 100
`define HWCU_UNIT_CYC (`HWCU_UNIT_NS / `HWCU_CLK_NS)
// Frame characters
`define HWCU_CH_CR 8'h0d
`define HWCU_CH_LEAD 8'h7e
`define HWCU_CH_STAR 8'h2a
`define HWCU_CH_ACK 8'h21
`define HWCU_CH_NAK 8'h3f
`define HWCU_CH_ZERO 8'h30
`define HWCU_CH_ONE 8'h31
`define HWCU_CH_TWO 8'h32
`define HWCU_CH_THREE 8'h33
`define HWCU_CH_FOUR 8'h34
`endif

/* src/hwcu_pkg.sv */
// Types and character helpers of the host watchdog command unit
package hwcu_pkg;
    typedef enum logic [1:0] {
        HWCU_ST_COLLECT = 2'b01,
        HWCU_ST_REPLY = 2'b10
    } hwcu_state_e;
    typedef logic [7:0] hwcu_char_t;
    // Nibble to upper-case hex character
    function automatic hwcu_char_t hwcu_hex_char(input logic [3:0] v);
        hwcu_char_t c;
        c = (v < 4'ha) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
        return c;
    endfunction
    // Hex character to {valid, nibble}
    function automatic logic [4:0] hwcu_hex_val(input hwcu_char_t c);
        logic [4:0] r;
        r = 5'h00;
        if (c >= 8'h30 && c <= 8'h39) r = {1'b1, c[3:0]};
        else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
            r = {1'b1, c[3:0] + 4'h9};
        return r;
    endfunction
endpackage

/* tb/hwcu_host_model.sv */
// Host-side model: sends command frames and gathers reply frames
`timescale 1ns/10ps
module hwcu_host_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Command characters towards the device
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_err,
    // Reply characters from the device
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Stall every other cycle when high
    input wire logic slow
);
    // ------------------------------------------------------------
    // Frame sender
    // ------------------------------------------------------------
    string reply;
    string last;
    int reply_cnt;

    // Idle link at start
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_err = 1'b0;
        reply = "";
        last = "";
        reply_cnt = 0;
    end

    // One char a cycle, CR closes; bad_at marks a line error
    task automatic send(input string s, input int bad_at);
        for (int i = 0; i <= s.len(); i++) begin
            @(posedge core_clk);
            rx_valid <= 1'b1;
            rx_data <= (i == s.len()) ? 8'h0d : s[i];
            rx_err <= (i == bad_at);
        end
        @(posedge core_clk);
        rx_valid <= 1'b0;
        rx_err <= 1'b0;
        rx_data <= ~rx_data; // No stale char on an idle line
    endtask

    // ------------------------------------------------------------
    // Reply side
    // ------------------------------------------------------------
    // Ready steady, or every other cycle when stalling
    always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= !slow || !tx_ready;
        end
    end

    // Gather reply chars; CR closes the reply
    always @(posedge core_clk) begin
        if (rstn && tx_valid && tx_ready) begin
            if (tx_data == 8'h0d) begin
                last = reply;
                reply = "";
                reply_cnt++;
            end else begin
                reply = {reply, string'(tx_data)};
            end
        end
    end
endmodule

/* tb/test_host_watchdog_command_unit.sv */
// Self-checking bench of the host watchdog command unit
`timescale 1ns/10ps
module test_host_watchdog_command_unit;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic core_clk, rstn, slow;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data, tx_data;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready, rx_valid, rx_err, tx_valid, tx_ready;
    logic nv_flag_in, nv_en_in, nv_flag, nv_en;
    logic [7:0] nv_period_in, nv_period, do_power_on_val, do_safe_val;
    int failures, check_count, c;

    hwcu_top #(.TICK_CYCLES(4), .BUF_LEN(12)) dut_u (
        .core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_data, .rx_err,
        .tx_valid, .tx_data, .tx_ready, .nv_flag_in, .nv_en_in,
        .nv_period_in, .nv_flag, .nv_en, .nv_period, .do_power_on_val,
        .do_safe_val);

    hwcu_host_model host_u (.core_clk, .rstn, .rx_valid, .rx_data,
        .rx_err, .tx_valid, .tx_data, .tx_ready, .slow);

    // 10 MHz clock
    always #50 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Compare and count
    task automatic check(input string seen, input string exp);
        check_count++;
        if (seen != exp) begin
            failures++;
            $display("BAD %0t seen '%s' expected '%s'", $time, seen, exp);
        end
    endtask

    // Append two-digit sum of all chars
    function automatic string with_cs(input string s);
        logic [7:0] sum;
        string t;
        sum = 8'h00;
        for (int i = 0; i < s.len(); i++) sum += s[i];
        t = $sformatf("%s%02h", s, sum);
        return t.toupper();
    endfunction

    // Bus write, both channels offered together
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        // A missing answer shows as valid 0
        check($sformatf("%h %h", s_axi_bvalid, s_axi_bresp),
              $sformatf("1 %h", er));
        s_axi_bready <= 1'b0;
    endtask

    // Bus read, masked data and response compared
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        check($sformatf("%h %h %h", s_axi_rvalid, s_axi_rdata & m,
              s_axi_rresp), $sformatf("1 %h %h", e, er));
        s_axi_rready <= 1'b0;
    endtask

    // Send a frame; empty exp means silence
    task automatic cmd(input string s, input int bad_at, input string exp);
        int n;
        int c0;
        n = 0;
        c0 = host_u.reply_cnt;
        host_u.send(s, bad_at);
        while (host_u.reply_cnt == c0 && n < 200) begin
            @(posedge core_clk);
            n++;
        end
        check((host_u.reply_cnt == c0) ? "" : host_u.last, exp);
    endtask

    // Counts, verdict, stop
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        rstn = 1'b0;
        slow = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        nv_flag_in = 1'b1;
        nv_en_in = 1'b0;
        nv_period_in = 8'h07;
        failures = 0;
        check_count = 0;
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd_chk(8'h00, 32'h1ff, 32'h001, 2'b00);
        rd_chk(8'h04, 32'hffff, 32'h0784 & 32'hff7f, 2'b00);
        rd_chk(8'h0c, 32'hffffffff, 32'h0, 2'b10);
        wr_chk(8'h0c, 32'h0, 2'b10);
        $display("test registers done");
        cmd("~010", -1, "!0104");
        cmd("~011", -1, "!01");
        cmd("~010", -1, "!0100");
        check($sformatf("%h", nv_flag), "0");
        $display("test status done");
        slow <= 1'b1;
        cmd("~0131FF", -1, "!01");
        cmd("~012", -1, "!011FF");
        cmd("~010", -1, "!0180");
        slow <= 1'b0;
        $display("test set done");
        cmd("~013105", -1, "!01");
        c = host_u.reply_cnt;
        for (int i = 0; i < 6; i++) host_u.send("~**", -1);
        repeat (5) @(posedge core_clk);
        check($sformatf("%h%h%h%0d", nv_en, nv_flag, nv_period,
              host_u.reply_cnt - c), "10050");
        repeat (40) @(posedge core_clk);
        check($sformatf("%h%h", nv_en, nv_flag), "01");
        cmd("~010", -1, "!0104");
        cmd("~012", -1, "!01005");
        cmd("~0131FF", -1, "!01");
        cmd("~010", -1, "!0184");
        cmd("~013005", -1, "!01");
        cmd("~012", -1, "!01005");
        $display("test timeout done");
        cmd("~013000", -1, "?01");
        cmd("~013205", -1, "?01");
        cmd("~019", -1, "?01");
        cmd("~020", -1, "");
        cmd("~010", 2, "");
        cmd("010", -1, "");
        cmd("~0100000000000", -1, "");
        $display("test refusals done");
        wr_chk(8'h08, 32'h00040605, 2'b00);
        wr_chk(8'h00, 32'h0000003a, 2'b00);
        cmd("~3a4", -1, "!3A0506");
        check($sformatf("%h %h", do_power_on_val, do_safe_val),
              "01 02");
        cmd("~014", -1, "");
        wr_chk(8'h00, 32'h0000013a, 2'b00);
        cmd(with_cs("~3A2"), -1, with_cs("!3A005"));
        cmd("~3A200", -1, "");
        $display("test masks and checksum done");
        end_sim();
    end

    // Hang guard, well past the expected run
    initial begin
        #2000000;
        failures++;
        end_sim();
    end
endmodule
